// ==== hdl/ppd_pkg.sv ====
// constants shared by the parallel port dma pin logic
// assumes a single 10 MHz clock and synchronous pin inputs
// Behaviour
// - drive and sample eight parallel data lines
// - bus strobes count only while acknowledge low
// - acknowledge inputs matter only in ecp mode
// - config bit picks one acknowledge input
// - high request asks dma for printer transfer
// - unselected request output left undriven
package ppd_pkg;
    localparam int          CLOCK_MHZ    = 10;
    localparam int          DATA_W       = 8;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          PIN_SEL_BIT  = 3;
    localparam int          SETUP_NS     = 500;
    localparam int          STROBE_NS    = 500;
    localparam int          SETUP_CYC    = (SETUP_NS * CLOCK_MHZ + 999) / 1000;
    localparam int          STROBE_CYC   = (STROBE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int          CNT_W        = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

    typedef enum logic [1:0] {
        PPD_IDLE   = 2'b00,
        PPD_SETUP  = 2'b01,
        PPD_STROBE = 2'b10,
        PPD_WAIT   = 2'b11
    } ppd_drain_e;
endpackage : ppd_pkg

// ==== hdl/ppd_fifo.sv ====
// byte fifo between the dma bus side and the printer side
// assumes one clock and an active low reset already synchronised
`timescale 1ns/1ps
module ppd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
    logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0]    count_reg,  count_next;
    logic             push, pop;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    always_comb begin
        in_ready    = (count_reg != FULL_CNT);
        out_valid   = (count_reg != '0);
        out_data    = mem_reg[rd_ptr_reg];
        push        = in_valid && in_ready;
        pop         = out_valid && out_ready;
        wr_ptr_next = push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
        rd_ptr_next = pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
        count_next  = count_reg + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end
endmodule : ppd_fifo

// ==== hdl/ppd_port.sv ====
// parallel port data lines and ecp dma request and acknowledge pins
// assumes a system dma controller on the bus side and printer logic
`timescale 1ns/1ps
module ppd_port
    import ppd_pkg::*;
#(
    parameter int FIFO_W = DATA_W,
    parameter int FIFO_D = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // configuration
    input  wire logic              ecp_mode_en,
    input  wire logic [7:0]        system_config_one,
    input  wire logic              port_reverse,
    // host bus side
    input  wire logic              bus_rd_b,
    input  wire logic              bus_wr_b,
    input  wire logic [DATA_W-1:0] bus_data_in,
    output logic      [DATA_W-1:0] bus_data_out,
    output logic                   bus_data_oe,
    // dma pins
    input  wire logic [1:0]        port_dma_ack_b,
    output logic      [1:0]        port_dma_request,
    output logic      [1:0]        port_dma_request_oe,
    // printer side
    input  wire logic [DATA_W-1:0] port_data_lines_in,
    output logic      [DATA_W-1:0] port_data_lines_out,
    output logic      [DATA_W-1:0] port_data_lines_oe,
    output logic                   peri_strobe_b,
    input  wire logic              peri_busy,
    input  wire logic              peri_valid,
    output logic                   peri_ready,
    input  wire logic              paper_out_input,
    output logic                   paper_out
);
    logic [1:0]        rst_sync_reg;
    logic              rst_n;
    logic              pin_sel, ack_sel_b, ack_active;
    logic              wr_prev_reg, rd_active_reg, rd_active_next;
    logic              wr_take, rd_now, rd_done, peri_take;
    logic              req_reg, req_next;
    logic              paper_reg;
    logic              f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [FIFO_W-1:0] f_in_data, f_out_data;
    logic [DATA_W-1:0] bus_out_reg, bus_out_next;
    logic [DATA_W-1:0] pd_reg, pd_next;
    ppd_drain_e        dr_reg, dr_next;
    logic [CNT_W-1:0]  cnt_reg, cnt_next;

    // reset release through two flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // acknowledge selection and bus strobe qualification
    always_comb begin
        pin_sel    = system_config_one[PIN_SEL_BIT];
        ack_sel_b  = pin_sel ? port_dma_ack_b[1] : port_dma_ack_b[0];
        ack_active = ecp_mode_en && !ack_sel_b;
        wr_take    = ack_active && !bus_wr_b && wr_prev_reg;
        rd_now     = ack_active && !bus_rd_b;
        rd_done    = rd_active_reg && !rd_now;
        rd_active_next = rd_now;
        peri_take  = port_reverse && peri_valid;
        peri_ready = port_reverse && f_in_ready;
        paper_out  = paper_reg;
    end

    // fifo hookup, forward fills from bus, reverse fills from lines
    always_comb begin
        f_in_valid  = port_reverse ? peri_take : wr_take;
        f_in_data   = port_reverse ? port_data_lines_in : bus_data_in;
        f_out_ready = port_reverse ? rd_done
                                   : (dr_reg == PPD_IDLE && !peri_busy && !paper_reg);
    end

    ppd_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // dma request level and read data
    always_comb begin
        if (!ecp_mode_en) begin
            req_next = 1'b0;
        end else if (port_reverse) begin
            req_next = f_out_valid;
        end else begin
            req_next = f_in_ready && !paper_reg;
        end
        bus_out_next = f_out_data;
    end

    // request pins, only the selected one is driven
    always_comb begin
        port_dma_request_oe[0] = ecp_mode_en && !pin_sel;
        port_dma_request_oe[1] = ecp_mode_en && pin_sel;
        port_dma_request       = port_dma_request_oe & {2{req_reg}};
        bus_data_out           = bus_out_reg;
        bus_data_oe            = rd_now && port_reverse;
    end

    // printer drain sequence in forward direction
    always_comb begin
        dr_next  = dr_reg;
        cnt_next = cnt_reg;
        pd_next  = pd_reg;
        case (dr_reg)
            PPD_IDLE: begin
                if (!port_reverse && f_out_valid && f_out_ready) begin
                    pd_next  = f_out_data;
                    cnt_next = CNT_W'(SETUP_CYC);
                    dr_next  = PPD_SETUP;
                end
            end
            PPD_SETUP: begin
                if (cnt_reg <= CNT_ONE) begin
                    cnt_next = CNT_W'(STROBE_CYC);
                    dr_next  = PPD_STROBE;
                end else begin
                    cnt_next = cnt_reg - CNT_ONE;
                end
            end
            PPD_STROBE: begin
                if (cnt_reg <= CNT_ONE) begin
                    cnt_next = CNT_ZERO;
                    dr_next  = PPD_WAIT;
                end else begin
                    cnt_next = cnt_reg - CNT_ONE;
                end
            end
            PPD_WAIT: begin
                if (!peri_busy) begin
                    dr_next = PPD_IDLE;
                end
            end
            default: begin
                dr_next = PPD_IDLE;
            end
        endcase
        port_data_lines_out = pd_reg;
        port_data_lines_oe  = port_reverse ? '0 : '1;
        peri_strobe_b       = (dr_reg != PPD_STROBE);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_prev_reg   <= 1'b1;
            rd_active_reg <= 1'b0;
            req_reg       <= 1'b0;
            paper_reg     <= 1'b0;
            bus_out_reg   <= '0;
            pd_reg        <= '0;
            dr_reg        <= PPD_IDLE;
            cnt_reg       <= CNT_ZERO;
        end else begin
            wr_prev_reg   <= bus_wr_b;
            rd_active_reg <= rd_active_next;
            req_reg       <= req_next;
            paper_reg     <= paper_out_input;
            bus_out_reg   <= bus_out_next;
            pd_reg        <= pd_next;
            dr_reg        <= dr_next;
            cnt_reg       <= cnt_next;
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    lines_follow_a: assert property (dr_reg == PPD_IDLE && f_out_valid && f_out_ready
        && !port_reverse |=> port_data_lines_out == $past(f_out_data))
        else $error("data lines did not take fifo byte");
    strobe_needs_ack_a: assert property (f_in_valid && !port_reverse
        |-> ecp_mode_en && !ack_sel_b && !bus_wr_b)
        else $error("write taken without acknowledge");
    ack_ecp_only_a: assert property (!ecp_mode_en |-> !bus_data_oe && !wr_take)
        else $error("acknowledge acted outside ecp mode");
    ack_pick_a: assert property (ack_active |-> !port_dma_ack_b[pin_sel])
        else $error("unselected acknowledge was used");
    req_ecp_a: assert property (ecp_mode_en && !port_reverse && f_in_ready && !paper_reg
        ##1 ecp_mode_en |-> port_dma_request[pin_sel])
        else $error("request missing with room in fifo");
    req_unsel_a: assert property (port_dma_request_oe[!pin_sel] == 1'b0
        && !port_dma_request[!pin_sel])
        else $error("unselected request is driven");
    req_off_a: assert property (!ecp_mode_en |-> port_dma_request_oe == 2'h0)
        else $error("request driven outside ecp mode");
    lines_hold_a: assert property (!peri_strobe_b |-> $stable(port_data_lines_out))
        else $error("data lines moved during strobe");
    rev_release_a: assert property (port_reverse |-> port_data_lines_oe == '0)
        else $error("data lines driven in reverse");
    read_gate_a: assert property (bus_data_oe |-> !bus_rd_b && !ack_sel_b)
        else $error("read data driven without strobe and acknowledge");
    req_full_a: assert property (!port_reverse && !f_in_ready |=> !req_reg)
        else $error("request kept with fifo full");
    paper_stall_a: assert property (paper_reg && !port_reverse |-> !f_out_ready)
        else $error("printer drained while paper is out");

    fwd_write_c: cover property (wr_take ##[1:20] !peri_strobe_b);
    rev_read_c: cover property (peri_take ##[1:20] rd_done);
    fifo_full_c: cover property (!f_in_ready);
    pin_one_c: cover property (pin_sel && port_dma_request[1]);
endmodule : ppd_port

// ==== test/ppd_printer.sv ====
// printer model: latches each strobed byte and answers with busy
// assumes forward bytes are stable on the lines while the strobe is low
`timescale 1ns/1ps
module ppd_printer (
    // pins
    input  wire logic       clock,
    input  wire logic       strobe_b,
    input  wire logic [7:0] lines,
    output logic            busy
);
    logic [7:0] got [$];
    logic [1:0] hold_reg = 2'h0;
    logic       busy_reg = 1'h0;
    assign busy = busy_reg;
    // busy lingers three cycles after the strobe
    always @(posedge clock) begin
        if (!strobe_b) begin
            if (!busy_reg) got.push_back(lines);
            busy_reg <= 1'h1;
            hold_reg <= 2'h2;
        end else if (hold_reg != 2'h0) begin
            hold_reg <= hold_reg - 2'h1;
        end else begin
            busy_reg <= 1'h0;
        end
    end
endmodule : ppd_printer

// ==== test/ppd_port_tb.sv ====
// bench for the parallel port dma pins, plays host and dma controller
// assumes the printer model in ppd_printer.sv
`timescale 1ns/1ps
`define CHK(a,b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module ppd_port_tb;
    import ppd_pkg::*;
    logic       clock, rst_b, ecp, rev, rd_b, wr_b, pv, po_in, busy, pr, po, oe, sb;
    logic [7:0] cfg, wdat, bout, lout, loe, rbyte, lin;
    logic [1:0] ack_b, req, req_oe;
    logic [7:0] exp_q [$];
    int         miscompares, n_compared, seed, sel, i;
    assign lin = (loe & lout) | (~loe & rbyte);
    ppd_port u_ppd_port (.clock(clock), .rst_b(rst_b), .ecp_mode_en(ecp),
        .system_config_one(cfg), .port_reverse(rev), .bus_rd_b(rd_b),
        .bus_wr_b(wr_b), .bus_data_in(wdat), .bus_data_out(bout), .bus_data_oe(oe),
        .port_dma_ack_b(ack_b), .port_dma_request(req), .port_dma_request_oe(req_oe),
        .port_data_lines_in(lin), .port_data_lines_out(lout),
        .port_data_lines_oe(loe), .peri_strobe_b(sb), .peri_busy(busy),
        .peri_valid(pv), .peri_ready(pr), .paper_out_input(po_in), .paper_out(po));
    ppd_printer u_printer (.clock(clock), .strobe_b(sb), .lines(lout), .busy(busy));
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    function automatic logic [1:0] oe_exp(input logic e, input int s);
        return e ? 2'(1 << s) : 2'h0;
    endfunction : oe_exp
    task tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task complete_run;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task bus_wr(input logic [7:0] b);
        wr_b = 1'h0;
        wdat = b;
        tick(1);
        wr_b = 1'h1;
        tick(1);
    endtask : bus_wr
    task wait_got(input int n);
        int k;
        for (k = 0; k < 4000 && u_printer.got.size() < n; k++) tick(1);
        if (k == 4000) begin
            miscompares++;
            complete_run();
        end
    endtask : wait_got
    task check_got;
        tick(40);
        `CHK(u_printer.got.size(), exp_q.size())
        foreach (exp_q[j]) `CHK(u_printer.got[j], exp_q[j])
        u_printer.got.delete();
        exp_q.delete();
    endtask : check_got
    initial begin
        seed = 32'h20BA;
        {rst_b, ecp, rev, pv, po_in, cfg, rbyte} = '0;
        {rd_b, wr_b, ack_b, wdat} = '1;
        tick(20);
        rst_b = 1'h1;
        tick(3);
        for (sel = 0; sel < 2; sel++) begin
            cfg = (8'($random(seed)) & 8'hF7) | 8'(sel << 3);
            ecp = 1'h0;
            tick(2);
            `CHK(req_oe, oe_exp(1'h0, sel))
            ack_b[sel] = 1'h0;
            bus_wr(8'h5A);
            ecp = 1'h1;
            ack_b = 2'h3;
            tick(2);
            `CHK(req_oe, oe_exp(1'h1, sel))
            `CHK(loe, 8'hFF)
            `CHK(req[sel], 1'h1)
            ack_b[1-sel] = 1'h0;
            bus_wr(8'hA5);
            ack_b = 2'h3;
            ack_b[sel] = 1'h0;
            for (i = 0; i < 4; i++) begin
                exp_q.push_back(8'($random(seed)));
                bus_wr(exp_q[i]);
            end
            ack_b = 2'h3;
            wait_got(4);
            check_got();
            $display("forward test done, pair %0d", sel);
            po_in = 1'h1;
            tick(3);
            `CHK(po, 1'h1)
            `CHK(req[sel], 1'h0)
            ack_b[sel] = 1'h0;
            for (i = 0; i < 17; i++) begin
                wdat = 8'($random(seed));
                if (i < 16) exp_q.push_back(wdat);
                bus_wr(wdat);
            end
            ack_b = 2'h3;
            po_in = 1'h0;
            wait_got(16);
            check_got();
            `CHK(po, 1'h0)
            $display("paper out fill test done, pair %0d", sel);
            rev = 1'h1;
            tick(2);
            `CHK(loe, 8'h00)
            for (i = 0; i < 3; i++) begin
                exp_q.push_back(8'($random(seed)));
                rbyte = exp_q[i];
                pv = 1'h1;
                tick(1);
                pv = 1'h0;
                rbyte = ~rbyte;
                tick(1);
            end
            `CHK(req[sel], 1'h1)
            ack_b[1-sel] = 1'h0;
            rd_b = 1'h0;
            tick(2);
            `CHK(oe, 1'h0)
            `CHK(pr, 1'h1)
            rd_b = 1'h1;
            ack_b = 2'h3;
            tick(2);
            foreach (exp_q[j]) begin
                ack_b[sel] = 1'h0;
                rd_b = 1'h0;
                tick(2);
                `CHK(oe, 1'h1)
                `CHK(bout, exp_q[j])
                rd_b = 1'h1;
                tick(2);
            end
            ack_b = 2'h3;
            tick(2);
            `CHK(req[sel], 1'h0)
            exp_q.delete();
            rev = 1'h0;
            tick(2);
            $display("reverse test done, pair %0d", sel);
        end
        complete_run();
    end
endmodule : ppd_port_tb
